// ### logic/user_reset_pkg.sv
// Constants shared by the user reset generator
package user_reset_pkg;
  localparam int unsigned SYNC_STAGES_DEF     = 2;
  localparam int unsigned SYNC_STAGES_MIN     = 2;
  localparam int unsigned DRI_DIV_DEF         = 4;
  localparam int unsigned DRI_DIV_MIN         = 2;
  localparam int unsigned REASON_WIDTH        = 8;
  localparam int unsigned REASON_FABRIC_BIT   = 4;
  localparam logic        ENABLE_RESET_VALUE  = 1'h0;
endpackage

// ### logic/user_reset_generator.sv
// Fabric reset generator merging power-on, pin, PLL lock and init status
`timescale 1ns/10ps
module user_reset_generator
  import user_reset_pkg::*;
#(
  parameter int unsigned SYNC_STAGES = SYNC_STAGES_DEF,
  parameter int unsigned DRI_DIV     = DRI_DIV_DEF
)(
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_fabric_por_n,
  input  wire logic                    i_reset_bank_supply_ok,
  input  wire logic                    i_clock_bank_supply_ok,
  input  wire logic                    i_external_reset_n,
  input  wire logic                    i_pll_lock,
  input  wire logic                    i_init_done,
  input  wire logic                    i_dynamic_reconfig_select_req,
  input  wire logic                    i_subsystem_reset_out_n,
  input  wire logic                    i_fabric_reset_enable_set,
  input  wire logic                    i_reason_clear,
  output logic                         o_fabric_reset_n,
  output logic                         o_subsystem_reset_in_n,
  output logic                         o_pll_power_down,
  output logic                         o_dynamic_reconfig_clock,
  output logic                         o_dynamic_reconfig_select,
  output logic                         o_transfer_hold,
  output logic                         o_peripheral_reset_n,
  output logic                         o_subsystem_in_reset,
  output logic [REASON_WIDTH-1:0]      o_reset_reason
);

  localparam int unsigned DIV_W = $clog2(DRI_DIV);

  if (SYNC_STAGES < SYNC_STAGES_MIN)
  begin : g_chk_sync
    $error("SYNC_STAGES must be at least two");
  end
  if (DRI_DIV < DRI_DIV_MIN || (DRI_DIV % 2) != 0)
  begin : g_chk_div
    $error("DRI_DIV must be even and at least two");
  end

  // Merged request; combinational on purpose so assertion needs no clock edge
  logic ext_qualified;
  logic reset_req;
  logic lock_meta_q;
  logic lock_sync_q;

  assign ext_qualified = i_fabric_por_n & i_reset_bank_supply_ok;
  // Synchronised lock also feeds the asynchronous request: a loss of lock asserts reset two clocks later
  assign reset_req = ~i_fabric_por_n | i_rst | (ext_qualified & ~i_external_reset_n)
                   | ~lock_sync_q | ~i_init_done;

  always_ff @(posedge i_sys_clk or negedge i_fabric_por_n)
  begin
    if (!i_fabric_por_n)
    begin
      lock_meta_q <= 1'h0;
      lock_sync_q <= 1'h0;
    end
    else
    begin
      lock_meta_q <= i_pll_lock;
      lock_sync_q <= lock_meta_q;
    end
  end

  // Release chain, each stage cleared asynchronously by the request
  logic [SYNC_STAGES-1:0] rel_q;
  logic [SYNC_STAGES-1:0] rel_d;

  always_comb
  begin
    rel_d = {rel_q[SYNC_STAGES-2:0], 1'h1};
  end

  always_ff @(posedge i_sys_clk or posedge reset_req)
  begin
    if (reset_req)
      rel_q <= '0;
    else
      rel_q <= rel_d;
  end

  // Single final flop fans out, so every consumer sees the same edge
  assign o_fabric_reset_n       = rel_q[SYNC_STAGES-1];
  assign o_subsystem_reset_in_n = rel_q[SYNC_STAGES-1];

  assign o_pll_power_down = ~(i_fabric_por_n & i_clock_bank_supply_ok);

  // Reconfiguration clock divider
  logic [DIV_W-1:0] div_cnt_q;
  logic [DIV_W-1:0] div_cnt_d;
  logic             cfg_clk_q;
  logic             cfg_clk_d;
  logic             dri_sel_q;
  logic             dri_sel_d;

  always_comb
  begin
    div_cnt_d = div_cnt_q + 1'h1;
    cfg_clk_d = cfg_clk_q;
    if (div_cnt_q == DIV_W'(DRI_DIV / 2 - 1))
    begin
      div_cnt_d = '0;
      cfg_clk_d = ~cfg_clk_q;
    end
    dri_sel_d = i_dynamic_reconfig_select_req;
  end

  always_ff @(posedge i_sys_clk or negedge i_fabric_por_n)
  begin
    if (!i_fabric_por_n)
    begin
      div_cnt_q <= '0;
      cfg_clk_q <= 1'h0;
      dri_sel_q <= 1'h0;
    end
    else
    begin
      div_cnt_q <= div_cnt_d;
      cfg_clk_q <= cfg_clk_d;
      dri_sel_q <= dri_sel_d;
    end
  end

  assign o_dynamic_reconfig_clock  = cfg_clk_q;
  assign o_dynamic_reconfig_select = dri_sel_q;

  // Subsystem status back into the fabric
  logic sub_meta_q;
  logic sub_sync_q;
  logic sub_sync_d;
  logic periph_rst_n_q;
  logic periph_rst_n_d;

  always_comb
  begin
    sub_sync_d     = sub_meta_q;
    periph_rst_n_d = sub_sync_q;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      sub_meta_q     <= 1'h0;
      sub_sync_q     <= 1'h0;
      periph_rst_n_q <= 1'h0;
    end
    else
    begin
      sub_meta_q     <= i_subsystem_reset_out_n;
      sub_sync_q     <= sub_sync_d;
      periph_rst_n_q <= periph_rst_n_d;
    end
  end

  assign o_transfer_hold      = ~sub_sync_q;
  assign o_peripheral_reset_n = periph_rst_n_q;

  // Fabric reset acceptance inside the subsystem
  logic                    fab_en_q;
  logic                    fab_en_d;
  logic [REASON_WIDTH-1:0] reason_q;
  logic [REASON_WIDTH-1:0] reason_d;
  logic                    taken;

  assign taken = fab_en_q & ~o_subsystem_reset_in_n;

  always_comb
  begin
    fab_en_d = fab_en_q | i_fabric_reset_enable_set;
    reason_d = reason_q;
    if (i_reason_clear)
      reason_d = '0;
    if (taken)
      reason_d[REASON_FABRIC_BIT] = 1'h1;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      fab_en_q <= ENABLE_RESET_VALUE;
      reason_q <= '0;
    end
    else
    begin
      fab_en_q <= fab_en_d;
      reason_q <= reason_d;
    end
  end

  assign o_subsystem_in_reset = taken;
  assign o_reset_reason       = reason_q;

  sequence s_req_gone;
    !reset_req [*2];
  endsequence

  sequence s_released;
    o_fabric_reset_n;
  endsequence

  release_delay_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $fell(reset_req) ##0 s_req_gone |-> !o_fabric_reset_n ##[0:2] s_released)
    else $error("Reset release not within two stages");
  release_sync_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $rose(o_fabric_reset_n) |-> !$past(reset_req) && $past(rel_q[0]))
    else $error("Reset released without clean chain");
  assert_async_a : assert property (@(posedge i_sys_clk)
    reset_req |-> !o_fabric_reset_n)
    else $error("Reset not asserted while requested");
  ext_ignored_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_fabric_por_n && !i_rst && !i_reset_bank_supply_ok && lock_sync_q && i_init_done) [*3]
    |-> o_fabric_reset_n)
    else $error("External reset honoured before bank ready");
  init_hold_a : assert property (@(posedge i_sys_clk)
    !i_init_done |-> !o_fabric_reset_n)
    else $error("Released before init done");
  pll_pd_a : assert property (@(posedge i_sys_clk)
    o_pll_power_down == !(i_fabric_por_n && i_clock_bank_supply_ok))
    else $error("PLL power-down wrong");
  hold_follow_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!i_subsystem_reset_out_n) [*3] |-> o_transfer_hold)
    else $error("Transfer hold missing");
  periph_rst_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
    ##1 o_peripheral_reset_n == $past(sub_sync_q))
    else $error("Peripheral reset not following subsystem");
  reason_set_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
    taken |=> o_reset_reason[REASON_FABRIC_BIT])
    else $error("Fabric reset reason not recorded");
  en_gate_a : assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !fab_en_q |-> !o_subsystem_in_reset)
    else $error("Fabric reset taken while disabled");
  dri_div_a : assert property (@(posedge i_sys_clk) disable iff (!i_fabric_por_n)
    $changed(cfg_clk_q) |=> !$changed(cfg_clk_q))
    else $error("Reconfiguration clock toggles too fast");

endmodule

// ### bench/subsystem_model.sv
// Behavioural processor subsystem whose reset status trails its fabric reset input
`timescale 1ns/10ps
module subsystem_model #(
  parameter int unsigned HOLD = 3
)(
  input  wire logic i_sys_clk,
  input  wire logic i_subsystem_reset_in_n,
  output logic      o_subsystem_reset_out_n
);
  int unsigned cnt_q;
  // Release lags the request so the hold path sees a real reset window
  always_ff @(posedge i_sys_clk or negedge i_subsystem_reset_in_n)
  begin
    if (!i_subsystem_reset_in_n)
    begin
      cnt_q                   <= 0;
      o_subsystem_reset_out_n <= 1'h0;
    end
    else if (cnt_q < HOLD)
      cnt_q <= cnt_q + 1;
    else
      o_subsystem_reset_out_n <= 1'h1;
  end
endmodule

// ### bench/tb_top.sv
// Self-checking bench for the user reset generator
`timescale 1ns/10ps
module tb_top;
  logic       clk, rst, por_n, rbank, cbank, ext_n, lock, init, sel_req, en_set, rclr;
  logic       frst_n, srst_n, pd, dclk, dsel, hold, prst_n, sin_rst, sub_out_n, dclk_prev;
  logic [7:0] reason;
  int         err_total, n_compared, seed, tog;
  user_reset_generator #(.SYNC_STAGES(2), .DRI_DIV(4)) i_user_reset_generator (
    .i_sys_clk(clk), .i_rst(rst), .i_fabric_por_n(por_n), .i_reset_bank_supply_ok(rbank),
    .i_clock_bank_supply_ok(cbank), .i_external_reset_n(ext_n), .i_pll_lock(lock), .i_init_done(init),
    .i_dynamic_reconfig_select_req(sel_req), .i_subsystem_reset_out_n(sub_out_n),
    .i_fabric_reset_enable_set(en_set), .i_reason_clear(rclr), .o_fabric_reset_n(frst_n),
    .o_subsystem_reset_in_n(srst_n), .o_pll_power_down(pd), .o_dynamic_reconfig_clock(dclk),
    .o_dynamic_reconfig_select(dsel), .o_transfer_hold(hold), .o_peripheral_reset_n(prst_n),
    .o_subsystem_in_reset(sin_rst), .o_reset_reason(reason));
  subsystem_model #(.HOLD(3)) i_subsystem_model (
    .i_sys_clk(clk), .i_subsystem_reset_in_n(srst_n), .o_subsystem_reset_out_n(sub_out_n));
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic exp_rst_n(input logic bank, input logic ext, input logic ini);
    return !((bank & !ext) | !ini);
  endfunction
  task automatic summarize();
    $display("Mismatches %0d, comparisons %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Generous bound: the whole sequence needs well under 1000 cycles
  initial
  begin
    #(25 * 4000);
    err_total++;
    summarize();
  end
  initial
  begin
    {rst, por_n, rbank, cbank, ext_n, lock, init, sel_req, en_set, rclr} = 10'h27C;
    err_total = 0;
    n_compared = 0;
    seed = 32'h3EB427E0;
    step(2);
    chk(pd, 1'h1);
    chk(dsel, 1'h0);
    chk(dclk, 1'h0);
    chk(frst_n, 1'h0);
    @(posedge clk) por_n <= 1'h1;
    step(8);
    @(posedge clk) rst <= 1'h0;
    step(10);
    chk({frst_n, srst_n, pd, hold, prst_n, sin_rst}, 6'h32);
    chk(reason, 8'h00);
    @(posedge clk) init <= 1'h0;
    #1 chk({frst_n, srst_n}, 2'h0);
    step(6);
    chk({hold, prst_n, sin_rst}, 3'h4);
    @(posedge clk) init <= 1'h1;
    step(1);
    chk(frst_n, 1'h0);
    step(1);
    chk({frst_n, srst_n}, 2'h3);
    step(10);
    chk({hold, prst_n, reason}, 10'h100);
    @(posedge clk) en_set <= 1'h1;
    @(posedge clk) {en_set, init} <= 2'h0;
    step(3);
    chk(sin_rst, 1'h1);
    @(posedge clk) init <= 1'h1;
    step(4);
    chk(reason, 8'h10);
    @(posedge clk) rclr <= 1'h1;
    @(posedge clk) rclr <= 1'h0;
    #1 chk(reason, 8'h00);
    @(posedge clk) lock <= 1'h0;
    step(3);
    chk(frst_n, 1'h0);
    @(posedge clk) lock <= 1'h1;
    step(3);
    chk(frst_n, 1'h0);
    step(1);
    chk(frst_n, 1'h1);
    tog = 0;
    dclk_prev = dclk;
    for (int k = 0; k < 40; k++)
    begin
      step(1);
      if (dclk !== dclk_prev)
        tog++;
      dclk_prev = dclk;
    end
    chk(8'(tog), 8'h14);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk) {por_n, cbank} <= 2'(i);
      #1 chk(pd, 1'(i != 3));
    end
    step(10);
    for (int k = 0; k < 40; k++)
    begin
      @(posedge clk);
      rbank   <= 1'($random(seed));
      ext_n   <= 1'($random(seed));
      init    <= ($random(seed) & 3) != 0;
      sel_req <= 1'($random(seed));
      step(1);
      chk(dsel, sel_req);
      step(4);
      chk(frst_n, exp_rst_n(rbank, ext_n, init));
    end
    summarize();
  end
endmodule
